//--- common/sbd_defs.vh
`ifndef SBD_DEFS_VH
`define SBD_DEFS_VH

// register offsets, byte addresses on the plain port
`define SBD_ADDR_W       8
`define SBD_OFS_DW0      8'h00
`define SBD_OFS_DW1      8'h04
`define SBD_OFS_DW2      8'h08
`define SBD_OFS_DW3      8'h0C
`define SBD_OFS_STAT     8'h10
`define SBD_OFS_CPUADDR  8'h14

// reset values
`define SBD_RST_WORD     32'h00000000

// dw0 fields (descriptor bits 31..0)
`define SBD_EP0_BIT      31
`define SBD_MPS_HI       28
`define SBD_MPS_LO       18
`define SBD_LEN_HI       17
`define SBD_LEN_LO       3
`define SBD_V_BIT        0

// dw1 fields (descriptor bits 63..32, minus 32)
`define SBD_HUB_HI       31
`define SBD_HUB_LO       25
`define SBD_PORT_HI      24
`define SBD_PORT_LO      18
`define SBD_SE_HI        17
`define SBD_SE_LO        16
`define SBD_SPLIT_BIT    14
`define SBD_KIND_HI      13
`define SBD_KIND_LO      12
`define SBD_TOK_HI       11
`define SBD_TOK_LO       10
`define SBD_DEV_HI       9
`define SBD_DEV_LO       3
`define SBD_EPH_HI       2
`define SBD_EPH_LO       0

// dw2 fields
`define SBD_RL_HI        28
`define SBD_RL_LO        25
`define SBD_PTR_HI       23
`define SBD_PTR_LO       8

// dw3 status fields
`define SBD_A_BIT        31
`define SBD_H_BIT        30
`define SBD_X_BIT        28
`define SBD_CERR_HI      24
`define SBD_CERR_LO      23
`define SBD_NAK_HI       22
`define SBD_NAK_LO       19
`define SBD_XFR_HI       14
`define SBD_XFR_LO       0

// encodings
`define SBD_SE_LOW       2'h2
`define SBD_SE_FULL      2'h0
`define SBD_KIND_CTRL    2'h0
`define SBD_KIND_ISO     2'h1
`define SBD_KIND_BULK    2'h2
`define SBD_TOK_OUT      2'h0
`define SBD_TOK_IN       2'h1
`define SBD_TOK_SETUP    2'h2

// limits and address mapping
`define SBD_FS_MAX_PKT   11'h040
`define SBD_RAM_BASE     32'h00000400
`define SBD_RAM_SHIFT    3

`endif

//--- src/sbd_field_dec.v
`timescale 1ns/10ps
`default_nettype none
`include "sbd_defs.vh"

module sbd_field_dec
(
	input  wire [31:0] i_dw0,
	input  wire [31:0] i_dw1,
	input  wire [31:0] i_dw2,
	output wire [3:0]  o_nak_reload_value,
	output wire [15:0] o_payload_buffer_pointer,
	output wire [6:0]  o_upstream_hub_id,
	output wire [6:0]  o_hub_port_index,
	output wire [1:0]  o_split_speed_select,
	output wire        o_split,
	output wire [1:0]  o_endpoint_kind,
	output wire [1:0]  o_token,
	output wire [6:0]  o_function_usb_id,
	output wire [3:0]  o_endpoint_number,
	output wire [10:0] o_max_payload_size,
	output wire [14:0] o_transfer_byte_budget,
	output wire        o_active
);

	// reserved bits are simply not looked at
	assign o_nak_reload_value       = i_dw2[`SBD_RL_HI:`SBD_RL_LO];
	assign o_payload_buffer_pointer = i_dw2[`SBD_PTR_HI:`SBD_PTR_LO];
	assign o_upstream_hub_id        = i_dw1[`SBD_HUB_HI:`SBD_HUB_LO];
	assign o_hub_port_index         = i_dw1[`SBD_PORT_HI:`SBD_PORT_LO];
	assign o_split_speed_select     = i_dw1[`SBD_SE_HI:`SBD_SE_LO];
	assign o_split                  = i_dw1[`SBD_SPLIT_BIT];
	assign o_endpoint_kind          = i_dw1[`SBD_KIND_HI:`SBD_KIND_LO];
	assign o_token                  = i_dw1[`SBD_TOK_HI:`SBD_TOK_LO];
	assign o_function_usb_id        = i_dw1[`SBD_DEV_HI:`SBD_DEV_LO];
	assign o_endpoint_number        = {i_dw1[`SBD_EPH_HI:`SBD_EPH_LO], i_dw0[`SBD_EP0_BIT]};
	assign o_max_payload_size       = i_dw0[`SBD_MPS_HI:`SBD_MPS_LO];
	assign o_transfer_byte_budget   = i_dw0[`SBD_LEN_HI:`SBD_LEN_LO];
	assign o_active                 = i_dw0[`SBD_V_BIT];

endmodule

`default_nettype wire

//--- src/sbd_engine.v
// Overview of operation
// - a zero NAK reload value makes the engine ignore the NAK counter.
// - for isochronous endpoints the reload value is never used.
// - buffer pointer is RAM word address, (CPU byte address - 400h) / 8.
// - hub address for split tokens comes from descriptor bits 63..57.
// - hub port number comes from descriptor bits 56..50.
// - speed select 10 means low speed, 00 full speed, only when split.
// - bit 46 zero is plain high speed, one is a split transaction.
// - endpoint type 00 is control, 10 is bulk.
// - token field 00 OUT, 01 IN, 10 SETUP.
// - function address comes from descriptor bits 41..35.
// - endpoint number is bits 34..32 above bit 31.
// - max packet length limits each packet; full speed at most 64 bytes.
// - transfer length bounds total bytes moved by the descriptor.
// - active flag cleared when descriptor completes or on fatal error.
// - nonzero reload and NAK counter reaching zero clears active.
// - error counter drops on bad response, reloads on NAK or NYET.
`timescale 1ns/10ps
`default_nettype none
`include "sbd_defs.vh"

module sbd_engine
(
	input  wire        i_clk_sys,
	input  wire        i_resetn,
	input  wire [7:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	input  wire        i_resp_ack,
	input  wire        i_resp_nak,
	input  wire        i_resp_nyet,
	input  wire        i_resp_err,
	input  wire [10:0] i_resp_bytes,
	output reg         o_tok_valid,
	output reg  [1:0]  o_tok_pid,
	output reg  [6:0]  o_tok_dev,
	output reg  [3:0]  o_tok_ep,
	output reg         o_tok_split,
	output reg  [6:0]  o_tok_hub,
	output reg  [6:0]  o_tok_port,
	output reg         o_tok_low_speed,
	output reg  [1:0]  o_tok_kind,
	output reg  [10:0] o_tok_len,
	output reg  [15:0] o_tok_buf
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_ISSUE = 2'h1;
	localparam ST_WAIT  = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// storage and field decode

	reg  [31:0] dw0_q;
	reg  [31:0] dw0_d;
	reg  [31:0] dw1_q;
	reg  [31:0] dw2_q;
	reg  [31:0] dw3_q;
	reg  [31:0] dw3_d;
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [1:0]  cerr_init_q;
	reg  [1:0]  cerr_init_d;
	reg         done_q;
	reg         done_d;
	reg         fatal_q;
	reg         fatal_d;
	reg  [10:0] pkt_len_q;

	wire [3:0]  nak_reload_value;
	wire [15:0] payload_buffer_pointer;
	wire [6:0]  upstream_hub_id;
	wire [6:0]  hub_port_index;
	wire [1:0]  split_speed_select;
	wire        split_flag;
	wire [1:0]  endpoint_kind;
	wire [1:0]  token_sel;
	wire [6:0]  function_usb_id;
	wire [3:0]  endpoint_number;
	wire [10:0] max_payload_size;
	wire [14:0] transfer_byte_budget;
	wire        active;

	sbd_field_dec u_dec
	(
		.i_dw0                    (dw0_q),
		.i_dw1                    (dw1_q),
		.i_dw2                    (dw2_q),
		.o_nak_reload_value       (nak_reload_value),
		.o_payload_buffer_pointer (payload_buffer_pointer),
		.o_upstream_hub_id        (upstream_hub_id),
		.o_hub_port_index         (hub_port_index),
		.o_split_speed_select     (split_speed_select),
		.o_split                  (split_flag),
		.o_endpoint_kind          (endpoint_kind),
		.o_token                  (token_sel),
		.o_function_usb_id        (function_usb_id),
		.o_endpoint_number        (endpoint_number),
		.o_max_payload_size       (max_payload_size),
		.o_transfer_byte_budget   (transfer_byte_budget),
		.o_active                 (active)
	);

	// smaller of two packet sizes
	function [10:0] min11;
		input [10:0] a;
		input [10:0] b;
		begin
			min11 = (a < b) ? a : b;
		end
	endfunction

	// remaining bytes clipped to packet width
	function [10:0] clip11;
		input [14:0] v;
		begin
			clip11 = (v > 15'h07FF) ? 11'h7FF : v[10:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// derived values

	wire        wr_dw0 = i_wr && (i_addr == `SBD_OFS_DW0);
	wire        wr_dw1 = i_wr && (i_addr == `SBD_OFS_DW1);
	wire        wr_dw2 = i_wr && (i_addr == `SBD_OFS_DW2);
	wire        wr_dw3 = i_wr && (i_addr == `SBD_OFS_DW3);
	wire [14:0] xfr_done   = dw3_q[`SBD_XFR_HI:`SBD_XFR_LO];
	wire [3:0]  nak_retry_counter = dw3_q[`SBD_NAK_HI:`SBD_NAK_LO];
	wire [1:0]  cerr       = dw3_q[`SBD_CERR_HI:`SBD_CERR_LO];
	wire [14:0] remaining  = transfer_byte_budget - xfr_done;
	// nak counting only for nonzero reload on non-isochronous endpoints
	wire        nak_count_en = (nak_reload_value != 4'h0) &&
		(endpoint_kind != `SBD_KIND_ISO);
	wire        low_speed  = split_flag && (split_speed_select == `SBD_SE_LOW);
	// full and low speed splits capped at the full speed limit
	wire [10:0] mps_eff    = split_flag ?
		min11(max_payload_size, `SBD_FS_MAX_PKT) : max_payload_size;
	wire [10:0] next_len   = min11(mps_eff, clip11(remaining));
	wire [14:0] xfr_sum    = xfr_done + {4'h0, i_resp_bytes};
	wire [14:0] xfr_new    = (xfr_sum > transfer_byte_budget) ?
		transfer_byte_budget : xfr_sum;
	wire [31:0] cpu_addr   = ({16'h0000, payload_buffer_pointer} << `SBD_RAM_SHIFT) +
		`SBD_RAM_BASE;
	wire [15:0] word_ofs   = {4'h0, xfr_done[14:3]};
	wire [15:0] buf_word   = payload_buffer_pointer + word_ofs;

	////////////////////////////////////////////////////////////////////////////////
	// execution state machine

	always @*
	begin
		state_d     = state_q;
		dw0_d       = wr_dw0 ? i_wdata : dw0_q;
		dw3_d       = wr_dw3 ? i_wdata : dw3_q;
		cerr_init_d = cerr_init_q;
		done_d      = done_q;
		fatal_d     = fatal_q;
		case (state_q)
			ST_IDLE:
			begin
				// start once the active flag is seen set and stable
				if (active && !wr_dw0)
				begin
					cerr_init_d = cerr;
					done_d      = 1'b0;
					fatal_d     = 1'b0;
					if (remaining == 15'h0000)
					begin
						// nothing left to move: finish at once
						dw0_d[`SBD_V_BIT] = wr_dw0 ? i_wdata[`SBD_V_BIT] : 1'b0;
						if (!wr_dw3)
							dw3_d[`SBD_A_BIT] = 1'b0;
						done_d = 1'b1;
					end
					else
						state_d = ST_ISSUE;
				end
			end
			ST_ISSUE:
			begin
				if (!active)
					state_d = ST_IDLE;
				else
					state_d = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (!active)
					state_d = ST_IDLE;
				else if (i_resp_ack)
				begin
					if (!wr_dw3)
						dw3_d[`SBD_XFR_HI:`SBD_XFR_LO] = xfr_new;
					if ((xfr_new >= transfer_byte_budget) || (i_resp_bytes < pkt_len_q))
					begin
						if (!wr_dw0)
							dw0_d[`SBD_V_BIT] = 1'b0;
						if (!wr_dw3)
							dw3_d[`SBD_A_BIT] = 1'b0;
						done_d  = 1'b1;
						state_d = ST_IDLE;
					end
					else
						state_d = ST_ISSUE;
				end
				else if (i_resp_nak || i_resp_nyet)
				begin
					if (!wr_dw3)
						dw3_d[`SBD_CERR_HI:`SBD_CERR_LO] = cerr_init_q;
					state_d = ST_ISSUE;
					if (i_resp_nak && nak_count_en)
					begin
						if (nak_retry_counter <= 4'h1)
						begin
							if (!wr_dw3)
							begin
								dw3_d[`SBD_NAK_HI:`SBD_NAK_LO] = 4'h0;
								dw3_d[`SBD_A_BIT]              = 1'b0;
							end
							if (!wr_dw0)
								dw0_d[`SBD_V_BIT] = 1'b0;
							done_d  = 1'b1;
							state_d = ST_IDLE;
						end
						else if (!wr_dw3)
							dw3_d[`SBD_NAK_HI:`SBD_NAK_LO] = nak_retry_counter - 4'h1;
					end
				end
				else if (i_resp_err)
				begin
					if (cerr <= 2'h1)
					begin
						if (!wr_dw3)
						begin
							dw3_d[`SBD_CERR_HI:`SBD_CERR_LO] = 2'h0;
							dw3_d[`SBD_X_BIT]                = 1'b1;
							dw3_d[`SBD_H_BIT]                = 1'b1;
							dw3_d[`SBD_A_BIT]                = 1'b0;
						end
						if (!wr_dw0)
							dw0_d[`SBD_V_BIT] = 1'b0;
						fatal_d = 1'b1;
						done_d  = 1'b1;
						state_d = ST_IDLE;
					end
					else
					begin
						if (!wr_dw3)
							dw3_d[`SBD_CERR_HI:`SBD_CERR_LO] = cerr - 2'h1;
						state_d = ST_ISSUE;
					end
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			state_q     <= ST_IDLE;
			dw0_q       <= `SBD_RST_WORD;
			dw1_q       <= `SBD_RST_WORD;
			dw2_q       <= `SBD_RST_WORD;
			dw3_q       <= `SBD_RST_WORD;
			cerr_init_q <= 2'h0;
			done_q      <= 1'b0;
			fatal_q     <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			dw0_q       <= dw0_d;
			dw3_q       <= dw3_d;
			cerr_init_q <= cerr_init_d;
			done_q      <= done_d;
			fatal_q     <= fatal_d;
			if (wr_dw1)
				dw1_q <= i_wdata;
			if (wr_dw2)
				dw2_q <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// token request outputs

	always @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			o_tok_valid     <= 1'b0;
			o_tok_pid       <= `SBD_TOK_OUT;
			o_tok_dev       <= 7'h00;
			o_tok_ep        <= 4'h0;
			o_tok_split     <= 1'b0;
			o_tok_hub       <= 7'h00;
			o_tok_port      <= 7'h00;
			o_tok_low_speed <= 1'b0;
			o_tok_kind      <= `SBD_KIND_CTRL;
			o_tok_len       <= 11'h000;
			o_tok_buf       <= 16'h0000;
			pkt_len_q       <= 11'h000;
		end
		else
		begin
			o_tok_valid <= (state_q == ST_ISSUE) && active;
			if (state_q == ST_ISSUE)
			begin
				o_tok_pid       <= token_sel;
				o_tok_dev       <= function_usb_id;
				o_tok_ep        <= endpoint_number;
				o_tok_split     <= split_flag;
				o_tok_hub       <= split_flag ? upstream_hub_id : 7'h00;
				o_tok_port      <= split_flag ? hub_port_index : 7'h00;
				o_tok_low_speed <= low_speed;
				o_tok_kind      <= endpoint_kind;
				o_tok_len       <= next_len;
				o_tok_buf       <= buf_word;
				pkt_len_q       <= next_len;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read port

	always @(posedge i_clk_sys)
	begin
		if (!i_resetn)
			o_rdata <= `SBD_RST_WORD;
		else if (i_rd)
		begin
			case (i_addr)
				`SBD_OFS_DW0:     o_rdata <= dw0_q;
				`SBD_OFS_DW1:     o_rdata <= dw1_q;
				`SBD_OFS_DW2:     o_rdata <= dw2_q;
				`SBD_OFS_DW3:     o_rdata <= dw3_q;
				`SBD_OFS_STAT:    o_rdata <= {26'h0000000, endpoint_kind == `SBD_KIND_BULK,
					nak_count_en, fatal_q, done_q, state_q};
				`SBD_OFS_CPUADDR: o_rdata <= cpu_addr;
				default:          o_rdata <= `SBD_RST_WORD;
			endcase
		end
		else
			o_rdata <= `SBD_RST_WORD;
	end

endmodule

`default_nettype wire

//--- bench/sbd_engine_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbd_defs.vh"

module sbd_engine_props
(
	input wire logic        i_clk_sys,
	input wire logic        i_resetn,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        o_tok_valid,
	input wire logic [1:0]  o_tok_pid,
	input wire logic [6:0]  o_tok_dev,
	input wire logic [3:0]  o_tok_ep,
	input wire logic        o_tok_split,
	input wire logic [6:0]  o_tok_hub,
	input wire logic [6:0]  o_tok_port,
	input wire logic        o_tok_low_speed,
	input wire logic [1:0]  o_tok_kind,
	input wire logic [10:0] o_tok_len
);
	logic [31:0] dw0_q;
	logic [31:0] dw1_q;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////////////////////////////////////////////
	// shadow of software descriptor writes
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			dw0_q <= 32'h0;
			dw1_q <= 32'h0;
		end
		else if (i_wr && i_addr == `SBD_OFS_DW0)
			dw0_q <= i_wdata;
		else if (i_wr && i_addr == `SBD_OFS_DW1)
			dw1_q <= i_wdata;
	end
	////////////////////////////////////////////////////////////////////////////////
	chk_hub_addr: assert property (o_tok_valid |->
		o_tok_hub == (o_tok_split ? dw1_q[31:25] : 7'h0))
		else $error("hub address mismatch");
	chk_port_num: assert property (o_tok_valid |->
		o_tok_port == (o_tok_split ? dw1_q[24:18] : 7'h0))
		else $error("hub port mismatch");
	chk_low_speed: assert property (o_tok_valid |->
		o_tok_low_speed == (dw1_q[14] && dw1_q[17:16] == 2'h2))
		else $error("speed select mismatch");
	chk_split_flag: assert property (o_tok_valid |-> o_tok_split == dw1_q[14])
		else $error("split flag mismatch");
	chk_ep_kind: assert property ($rose(o_tok_valid) |-> o_tok_kind == dw1_q[13:12])
		else $error("endpoint kind mismatch");
	chk_token_pid: assert property (o_tok_valid |->
		o_tok_pid == dw1_q[11:10] ##1 $stable(o_tok_pid))
		else $error("token pid mismatch");
	chk_func_addr: assert property (o_tok_valid |-> o_tok_dev == dw1_q[9:3])
		else $error("function address mismatch");
	chk_ep_num: assert property (o_tok_valid |-> o_tok_ep == {dw1_q[2:0], dw0_q[31]})
		else $error("endpoint number mismatch");
	chk_len_cap: assert property (o_tok_valid |-> o_tok_len <= dw0_q[28:18]
		&& o_tok_len <= dw0_q[17:3] && (!o_tok_split || o_tok_len <= 11'h040))
		else $error("packet length too large");
	cover property (o_tok_valid && o_tok_low_speed);
	cover property (o_tok_valid && !o_tok_split);
	cover property (o_tok_valid && o_tok_pid == 2'h2);
endmodule

bind sbd_engine sbd_engine_props sbd_engine_props_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_tok_valid(o_tok_valid),
	.o_tok_pid(o_tok_pid), .o_tok_dev(o_tok_dev), .o_tok_ep(o_tok_ep), .o_tok_split(o_tok_split),
	.o_tok_hub(o_tok_hub), .o_tok_port(o_tok_port), .o_tok_low_speed(o_tok_low_speed),
	.o_tok_kind(o_tok_kind), .o_tok_len(o_tok_len));
`default_nettype wire

//--- bench/sbd_hub_model.sv
`timescale 1ns/10ps
`default_nettype none

module sbd_hub_model
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_tok_valid,
	input  wire logic [10:0] i_tok_len,
	input  wire logic [1:0]  i_mode,
	input  wire logic [3:0]  i_gap,
	output logic             o_ack,
	output logic             o_nak,
	output logic             o_nyet,
	output logic             o_err,
	output logic [10:0]      o_bytes
);
	logic [4:0] cnt_q = 5'h0;
	initial {o_ack, o_nak, o_nyet, o_err, o_bytes} = 15'h0;
	////////////////////////////////////////////////////////////////////////////////
	// answers each token gap+1 cycles after it is seen, byte lines scrambled between acks
	always @(posedge i_clk_sys)
	begin
		{o_ack, o_nak, o_nyet, o_err} <= 4'h0;
		o_bytes <= ~o_bytes;
		if (i_tok_valid)
			cnt_q <= {1'h0, i_gap} + 5'h1;
		else if (cnt_q != 5'h0)
		begin
			cnt_q <= cnt_q - 5'h1;
			if (cnt_q == 5'h1)
			begin
				case (i_mode)
					2'h0:
					begin
						o_ack   <= 1'h1;
						o_bytes <= i_tok_len;
					end
					2'h1: o_nak <= 1'h1;
					2'h2: o_err <= 1'h1;
					default: o_nyet <= 1'h1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/sbd_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbd_defs.vh"

module sbd_engine_tb;
	logic        i_clk_sys = 1'h0;
	logic        i_resetn  = 1'h0;
	logic [7:0]  i_addr    = 8'h0;
	logic [31:0] i_wdata   = 32'h0;
	logic        i_wr      = 1'h0;
	logic        i_rd      = 1'h0;
	logic [1:0]  mode      = 2'h0;
	logic [3:0]  gap       = 4'h0;
	logic [31:0] rd_q;
	wire [31:0]  o_rdata;
	wire         ack, nak, nyet, err, o_tok_valid, o_tok_split, o_tok_low_speed;
	wire [10:0]  bytes, o_tok_len;
	wire [1:0]   o_tok_pid, o_tok_kind;
	wire [6:0]   o_tok_dev, o_tok_hub, o_tok_port;
	wire [3:0]   o_tok_ep;
	wire [15:0]  o_tok_buf;
	int          n_errors = 0;
	int          n_compared = 0;
	int          n;
	always #10 i_clk_sys = ~i_clk_sys;
	sbd_engine sbd_engine_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_resp_ack(ack),
		.i_resp_nak(nak), .i_resp_nyet(nyet), .i_resp_err(err), .i_resp_bytes(bytes),
		.o_tok_valid(o_tok_valid), .o_tok_pid(o_tok_pid), .o_tok_dev(o_tok_dev),
		.o_tok_ep(o_tok_ep), .o_tok_split(o_tok_split), .o_tok_hub(o_tok_hub),
		.o_tok_port(o_tok_port), .o_tok_low_speed(o_tok_low_speed), .o_tok_kind(o_tok_kind),
		.o_tok_len(o_tok_len), .o_tok_buf(o_tok_buf));
	sbd_hub_model sbd_hub_model_i (.i_clk_sys(i_clk_sys), .i_tok_valid(o_tok_valid),
		.i_tok_len(o_tok_len), .i_mode(mode), .i_gap(gap), .o_ack(ack), .o_nak(nak),
		.o_nyet(nyet), .o_err(err), .o_bytes(bytes));
	////////////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("summary: %0d compared, %0d mismatches", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge i_clk_sys);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'h0;
		#1 rd_q = o_rdata;
	endtask
	task arm(input logic [31:0] d0, input logic [31:0] d1,
		input logic [31:0] d2, input logic [31:0] d3);
		wr(`SBD_OFS_DW1, d1);
		wr(`SBD_OFS_DW2, d2);
		wr(`SBD_OFS_DW3, d3);
		wr(`SBD_OFS_DW0, d0);
	endtask
	task wait_tok;
		int k;
		k = 0;
		do
		begin
			@(posedge i_clk_sys);
			#1 k++;
		end
		while (o_tok_valid !== 1'h1 && k < 60);
		if (k >= 60)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t no token", $time);
			wrap_up;
		end
	endtask
	task cnt_tok(input int win);
		n = 0;
		repeat (win)
		begin
			@(posedge i_clk_sys);
			#1 if (o_tok_valid === 1'h1) n++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_split_bulk;
		logic [31:0] d0;
		d0 = {1'h1, 2'h0, 11'h200, 15'h0050, 2'h3, 1'h1};
		mode = 2'h0;
		gap = 4'h0;
		arm(d0, {7'h55, 7'h13, 2'h2, 1'h0, 1'h1, 2'h2, 2'h1, 7'h2A, 3'h5},
			{3'h0, 4'h0, 1'h0, 16'h1234, 8'h0}, 32'h00010000);
		wait_tok;
		chk(o_tok_ep, 4'hB);
		chk(o_tok_low_speed, 1'h1);
		chk(o_tok_len, 11'h040);
		chk(o_tok_buf, 16'h1234);
		wait_tok;
		chk(o_tok_len, 11'h010);
		chk(o_tok_buf, 16'h1234 + 16'h0008);
		repeat (4) @(posedge i_clk_sys);
		rd(`SBD_OFS_DW0);
		chk(rd_q, d0 & ~32'h1);
		rd(`SBD_OFS_DW3);
		chk(rd_q[18:0], 19'h10050);
		rd(`SBD_OFS_CPUADDR);
		chk(rd_q, (32'h1234 << 3) + 32'h400);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40);
		chk(rd_q, 32'h0);
		wr(`SBD_OFS_DW0, d0);
		cnt_tok(8);
		chk(n, 0);
		rd(`SBD_OFS_DW0);
		chk(rd_q[0], 1'h0);
		rd(`SBD_OFS_STAT);
		chk(rd_q, 32'h00000024);
		$display("test split bulk done");
	endtask
	task t_nak_limit;
		mode = 2'h1;
		gap = 4'h5;
		arm({1'h0, 2'h0, 11'h008, 15'h0010, 3'h1}, {7'h7F, 7'h7F, 2'h2, 4'h0, 2'h0, 7'h03, 3'h0},
			{3'h0, 4'h2, 1'h0, 16'h0040, 8'h0}, {7'h0, 2'h3, 4'h2, 19'h0});
		wait_tok;
		chk(o_tok_hub, 7'h0);
		chk(o_tok_split, 1'h0);
		chk(o_tok_low_speed, 1'h0);
		chk(o_tok_pid, 2'h0);
		cnt_tok(40);
		chk(n, 1);
		rd(`SBD_OFS_DW0);
		chk(rd_q[0], 1'h0);
		rd(`SBD_OFS_STAT);
		chk(rd_q, 32'h00000014);
		$display("test nak limit done");
	endtask
	task t_nak_ignored;
		logic [31:0] d0;
		d0 = {1'h0, 2'h0, 11'h008, 15'h0010, 3'h1};
		mode = 2'h1;
		gap = 4'h0;
		arm(d0, {18'h0, 2'h2, 2'h1, 10'h0}, 32'h0, {7'h0, 2'h3, 4'h1, 19'h0});
		cnt_tok(30);
		chk(n > 2, 1'h1);
		mode = 2'h3;
		cnt_tok(20);
		chk(n > 2, 1'h1);
		rd(`SBD_OFS_DW0);
		chk(rd_q[0], 1'h1);
		wr(`SBD_OFS_DW0, d0 & ~32'h1);
		mode = 2'h1;
		arm(d0, {18'h0, 2'h1, 2'h1, 10'h0}, {3'h0, 4'h1, 25'h0}, {7'h0, 2'h3, 4'h1, 19'h0});
		cnt_tok(30);
		chk(n > 2, 1'h1);
		wr(`SBD_OFS_DW0, d0 & ~32'h1);
		$display("test nak ignored done");
	endtask
	task t_err_fatal;
		mode = 2'h2;
		gap = 4'h2;
		repeat (4) @(posedge i_clk_sys);
		arm({1'h0, 2'h0, 11'h040, 15'h0008, 3'h1}, {7'h01, 7'h02, 2'h0, 2'h1, 2'h0, 2'h2, 10'h29},
			{3'h0, 4'h0, 1'h0, 16'h0100, 8'h0}, {7'h0, 2'h2, 23'h0});
		wait_tok;
		chk(o_tok_pid, 2'h2);
		chk(o_tok_kind, 2'h0);
		chk(o_tok_low_speed, 1'h0);
		cnt_tok(30);
		chk(n, 1);
		rd(`SBD_OFS_DW0);
		chk(rd_q[0], 1'h0);
		rd(`SBD_OFS_DW3);
		chk(rd_q[28], 1'h1);
		rd(`SBD_OFS_STAT);
		chk(rd_q, 32'h0000000C);
		$display("test error fatal done");
	endtask
	initial
	begin
		repeat (8) @(posedge i_clk_sys);
		i_resetn <= 1'h1;
		t_split_bulk;
		t_nak_limit;
		t_nak_ignored;
		t_err_fatal;
		wrap_up;
	end
endmodule
`default_nettype wire
